// ---- rsc_board_model.sv ----
// rsc_board_model: board side of the straps, pull-ups and master reset line.
// assumes the bench asks for reset and pin drive through plain levels.
`timescale 1ns/1ps
`default_nettype none
module rsc_board_model
  import rsc_pkg::*;
(
  input wire logic mr_assert,
  input wire logic [RSC_NUM_GPIO-1:0] drive_en,
  input wire logic [RSC_NUM_GPIO-1:0] drive_val,
  input wire logic pin8_low,
  output logic master_reset_low,
  output logic [RSC_NUM_GPIO-1:0] gpio_pin
);
  // reset line follows the request, active low on the board
  assign master_reset_low = ~mr_assert;
  // undriven pins sit at the pull-up level; during reset pin 8 only drops when a fault is asked for
  // no pin doubles as a test access pin here, so every strap is free of that role
  always_comb
  begin
    for (int i = 0; i < RSC_NUM_GPIO; i++)
      gpio_pin[i] = drive_en[i] ? drive_val[i] : 1'b1;
    if (mr_assert)
      gpio_pin[RSC_PIN_HOLD_HI] = ~pin8_low;
  end
endmodule
`default_nettype wire

// ---- rsc_pkg.sv ----
// rsc_pkg: constants and carrier types for the reset strap configuration selector.
// assumes a single 200 MHz ref_clk domain and a 16-pin general-purpose bank.
package rsc_pkg;

  // pin bank
  localparam int unsigned RSC_NUM_GPIO = 16;
  localparam int unsigned RSC_IDX_W = 16;
  localparam int unsigned RSC_PIN_AUX_SEL = 9;
  localparam int unsigned RSC_PIN_HOLD_HI = 8;
  localparam int unsigned RSC_DEF_SEL_W = 4;
  localparam int unsigned RSC_NUM_OCLK = 4;

  // reset values
  localparam logic [15:0] RSC_MASK_NONE = 16'h0000;
  localparam logic [15:0] RSC_DEF_SEL_MASK = 16'h000f;
  localparam logic [15:0] RSC_IDX_RST = 16'h0000;
  localparam logic [3:0] RSC_OCLK_OFF = 4'h0;
  localparam logic [15:0] RSC_GPIO_ALL_IN = 16'h0000;
  localparam logic [15:0] RSC_GPIO_IDLE = 16'hffff;

  // start-up sequence
  typedef enum logic [2:0] {
    RSC_ST_IDLE = 3'b000,
    RSC_ST_OTP_LOAD = 3'b001,
    RSC_ST_EE_SEARCH = 3'b010,
    RSC_ST_PWR_UP = 3'b011,
    RSC_ST_PLL_CAL = 3'b100,
    RSC_ST_PLL_LOCK = 3'b101,
    RSC_ST_RUN = 3'b110
  } rsc_state_t;

  // captured strap results
  typedef struct packed {
    logic aux_i2c;
    logic slave_a2;
    logic eeprom_dis;
    logic [15:0] cfg_index;
  } rsc_strap_t;

  // pin-function assignment from the factory information block
  typedef struct packed {
    logic [15:0] cfg_sel;
    logic [15:0] addr_a2;
    logic [15:0] ee_dis;
  } rsc_pinmap_t;

  // later overwrite from loaded data or serial writes
  typedef struct packed {
    logic valid;
    logic aux_i2c;
    logic slave_a2;
  } rsc_ovr_t;

endpackage

// ---- rsc_strap_cfg.sv ----
// rsc_strap_cfg: samples the pin straps at master reset release, derives the
// start-up settings and walks the start-up sequence.
// assumes master_reset_low and gpio_pin come from the board (asynchronous);
// pin map, load status and overwrites come from ref_clk logic.
// Behaviour
// - capture every pin level at master reset rising edge, derive start-up settings.
// - captured pin 9 low picks SPI, high picks I2C for auxiliary port.
// - with no select pins assigned, pins 3..0 form the configuration index.
// - undriven default select pins read high, giving configuration 15.
// - any number of arbitrary pins, up to all 16, may be assigned to configuration selection.
// - lowest assigned pin is index LSB, rising in pin order to MSB.
// - fewer than four assigned pins fill low bits, upper bits zero.
// - more than four assigned pins form a wider index.
// - index only chooses stored configurations; no effect when part unprogrammed.
// - no pin assigned to A2 makes slave address bit A2 zero.
// - several A2 pins: only the highest-numbered one sets the bit.
// - A2 strap ignored when pin 9 selected SPI.
// - aux protocol and A2 strap results stay overwritable by loaded data or serial writes.
// - high on an EEPROM-disable pin stops EEPROM reads at start-up.
// - no EEPROM-disable pin means the EEPROM search is attempted.
// - any EEPROM-disable pin high disables access.
// - without loaded configuration, output clocks off and all pins inputs.
// - load configuration first, then regulators, clocks, PLL calibrate and lock.
// - stored configuration failing checksum is skipped, registers stay default.
`timescale 1ns/1ps
`default_nettype none
module rsc_strap_cfg
  import rsc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic master_reset_low,
  input wire logic [RSC_NUM_GPIO-1:0] gpio_pin,
  input wire rsc_pinmap_t pin_map,
  input wire rsc_ovr_t ovr,
  input wire logic otp_programmed,
  input wire logic otp_load_done,
  input wire logic otp_csum_err,
  input wire logic [RSC_NUM_OCLK-1:0] otp_oclk_en,
  input wire logic [RSC_NUM_GPIO-1:0] otp_gpio_out,
  input wire logic ee_search_done,
  input wire logic pll_cal_done,
  input wire logic pll_locked,
  output rsc_strap_t strap_q,
  output logic otp_load_req_q,
  output logic cfg_loaded_q,
  output logic ee_search_req_q,
  output logic regulator_en_q,
  output logic clocks_en_q,
  output logic pll_cal_req_q,
  output logic pll_lock_en_q,
  output logic [RSC_NUM_OCLK-1:0] oclk_en_q,
  output logic [RSC_NUM_GPIO-1:0] gpio_out_mode_q,
  output logic hold_pin_err_q,
  output logic startup_done_q
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // packs the assigned pins into an index, lowest pin first
  function automatic logic [RSC_IDX_W-1:0] pack_sel(input logic [RSC_NUM_GPIO-1:0] pins,
                                                    input logic [RSC_NUM_GPIO-1:0] mask);
    logic [RSC_IDX_W-1:0] idx;
    int unsigned k;
    idx = RSC_IDX_RST;
    k = 0;
    for (int unsigned i = 0; i < RSC_NUM_GPIO; i++)
    begin
      if (mask[i])
      begin
        idx[k[3:0]] = pins[i];
        k = k + 1;
      end
    end
    return idx;
  endfunction

  // value of the highest-numbered assigned pin, zero when none
  function automatic logic top_pin(input logic [RSC_NUM_GPIO-1:0] pins,
                                   input logic [RSC_NUM_GPIO-1:0] mask);
    logic v;
    v = 1'b0;
    for (int unsigned i = 0; i < RSC_NUM_GPIO; i++)
    begin
      if (mask[i])
      begin
        v = pins[i];
      end
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic mrl_s1_q;
  logic mrl_s2_q;
  logic mrl_s3_q;
  logic [RSC_NUM_GPIO-1:0] gpio_s1_q;
  logic [RSC_NUM_GPIO-1:0] gpio_s2_q;
  logic release_edge;

  // two stages before any logic; the third only marks the release and reset-entry edges
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      mrl_s1_q <= 1'b0;
      mrl_s2_q <= 1'b0;
      mrl_s3_q <= 1'b0;
    end
    else
    begin
      mrl_s1_q <= master_reset_low;
      mrl_s2_q <= mrl_s1_q;
      mrl_s3_q <= mrl_s2_q;
    end
  end

  // pins share the reset path latency, so the sample lines up with the edge
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      gpio_s1_q <= RSC_GPIO_IDLE; // pull-up level, so no false pin 8 fault after reset
      gpio_s2_q <= RSC_GPIO_IDLE;
    end
    else
    begin
      gpio_s1_q <= gpio_pin;
      gpio_s2_q <= gpio_s1_q;
    end
  end

  assign release_edge = mrl_s2_q & ~mrl_s3_q;

  ////////////////////////////////////////////////////////////////////////////
  // strap derivation

  rsc_strap_t strap_d;
  logic [RSC_NUM_GPIO-1:0] sel_mask;

  // default select pins apply only when the map assigns none
  always_comb
  begin
    sel_mask = (pin_map.cfg_sel == RSC_MASK_NONE) ? RSC_DEF_SEL_MASK : pin_map.cfg_sel;
    strap_d.aux_i2c = gpio_s2_q[RSC_PIN_AUX_SEL];
    strap_d.slave_a2 = strap_d.aux_i2c & top_pin(gpio_s2_q, pin_map.addr_a2);
    strap_d.eeprom_dis = |(gpio_s2_q & pin_map.ee_dis);
    strap_d.cfg_index = pack_sel(gpio_s2_q, sel_mask);
  end

  // sample only at release; pins may toggle freely afterwards
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      strap_q <= '0;
    end
    else if (release_edge)
    begin
      strap_q <= strap_d;
    end
    else if (ovr.valid)
    begin
      strap_q.aux_i2c <= ovr.aux_i2c;
      strap_q.slave_a2 <= ovr.slave_a2;
    end
  end

  // pin 8 must read high throughout the reset period; the flag stands until the
  // next master reset begins so it is still visible after release; set wins
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      hold_pin_err_q <= 1'b0;
    end
    else if (!mrl_s2_q && !gpio_s2_q[RSC_PIN_HOLD_HI])
    begin
      hold_pin_err_q <= 1'b1;
    end
    else if (!mrl_s2_q && mrl_s3_q)
    begin
      hold_pin_err_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // start-up sequence

  rsc_state_t state_q;
  rsc_state_t state_d;
  logic ee_dis_now;

  // at the release edge strap_q still holds the last boot, so take the fresh value
  assign ee_dis_now = release_edge ? strap_d.eeprom_dis : strap_q.eeprom_dis;

  // configuration loads before any power or clock bring-up
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      RSC_ST_IDLE:
      begin
        if (release_edge)
        begin
          state_d = otp_programmed ? RSC_ST_OTP_LOAD : RSC_ST_EE_SEARCH;
        end
      end
      RSC_ST_OTP_LOAD:
      begin
        if (otp_load_done)
        begin
          state_d = RSC_ST_EE_SEARCH;
        end
      end
      RSC_ST_EE_SEARCH:
      begin
        if (strap_q.eeprom_dis || ee_search_done)
        begin
          state_d = RSC_ST_PWR_UP;
        end
      end
      RSC_ST_PWR_UP:
      begin
        state_d = RSC_ST_PLL_CAL;
      end
      RSC_ST_PLL_CAL:
      begin
        if (pll_cal_done)
        begin
          state_d = RSC_ST_PLL_LOCK;
        end
      end
      RSC_ST_PLL_LOCK:
      begin
        if (pll_locked)
        begin
          state_d = RSC_ST_RUN;
        end
      end
      RSC_ST_RUN:
      begin
        state_d = RSC_ST_RUN;
      end
      default:
      begin
        state_d = RSC_ST_IDLE;
      end
    endcase
    if (!mrl_s2_q)
    begin
      state_d = RSC_ST_IDLE; // a new master reset restarts everything
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state_q <= RSC_ST_IDLE;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // request and enable levels follow the next state so they are registered
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      otp_load_req_q <= 1'b0;
      ee_search_req_q <= 1'b0;
      regulator_en_q <= 1'b0;
      clocks_en_q <= 1'b0;
      pll_cal_req_q <= 1'b0;
      pll_lock_en_q <= 1'b0;
      startup_done_q <= 1'b0;
    end
    else
    begin
      otp_load_req_q <= (state_d == RSC_ST_OTP_LOAD);
      ee_search_req_q <= (state_d == RSC_ST_EE_SEARCH) && !ee_dis_now;
      regulator_en_q <= (state_d >= RSC_ST_PWR_UP);
      clocks_en_q <= (state_d >= RSC_ST_PWR_UP);
      pll_cal_req_q <= (state_d == RSC_ST_PLL_CAL);
      pll_lock_en_q <= (state_d >= RSC_ST_PLL_LOCK);
      startup_done_q <= (state_d == RSC_ST_RUN);
    end
  end

  // stored settings only take effect from a good load; else defaults stand
  always_ff @(posedge ref_clk)
  begin
    if (reset || !mrl_s2_q)
    begin
      cfg_loaded_q <= 1'b0;
      oclk_en_q <= RSC_OCLK_OFF;
      gpio_out_mode_q <= RSC_GPIO_ALL_IN;
    end
    else if (state_q == RSC_ST_OTP_LOAD && otp_load_done && !otp_csum_err)
    begin
      cfg_loaded_q <= 1'b1;
      oclk_en_q <= otp_oclk_en;
      gpio_out_mode_q <= otp_gpio_out; // failed checksum never reaches here
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_strap_aux_sel: assert property (release_edge |=> strap_q.aux_i2c == $past(gpio_s2_q[RSC_PIN_AUX_SEL]))
    else $error("aux port protocol not taken from pin 9");
  a_strap_hold_val: assert property (!release_edge && !ovr.valid |=> $stable(strap_q))
    else $error("strap result changed without release or overwrite");
  a_default_sel_idx: assert property (release_edge && pin_map.cfg_sel == RSC_MASK_NONE
    |=> strap_q.cfg_index == {12'h000, $past(gpio_s2_q[3:0])})
    else $error("default select index not pins 3..0");
  a_a2_spi_zero: assert property (release_edge && !gpio_s2_q[RSC_PIN_AUX_SEL] |=> !strap_q.slave_a2)
    else $error("A2 set while SPI selected");
  a_a2_none_zero: assert property (release_edge && pin_map.addr_a2 == RSC_MASK_NONE |=> !strap_q.slave_a2)
    else $error("A2 set with no pin assigned");
  a_ee_disable_any: assert property (release_edge && |(gpio_s2_q & pin_map.ee_dis) |=> strap_q.eeprom_dis)
    else $error("EEPROM disable pin high but access kept");
  a_ee_skip_req: assert property (strap_q.eeprom_dis |-> !ee_search_req_q)
    else $error("EEPROM searched while disabled");
  a_hold_pin_flag: assert property (!mrl_s2_q && !gpio_s2_q[RSC_PIN_HOLD_HI] |=> hold_pin_err_q)
    else $error("pin 8 low in reset but no fault flagged");
  a_load_before_pwr: assert property ($rose(regulator_en_q) |-> $past(state_q) == RSC_ST_EE_SEARCH)
    else $error("regulators enabled before configuration step");
  a_csum_keep_def: assert property (state_q == RSC_ST_OTP_LOAD && otp_load_done && otp_csum_err
    && !cfg_loaded_q |=> !cfg_loaded_q && oclk_en_q == RSC_OCLK_OFF)
    else $error("bad checksum configuration applied");
  a_unprog_no_load: assert property (release_edge && !otp_programmed |=> ##[0:1] !otp_load_req_q)
    else $error("OTP load requested on unprogrammed part");
  a_clk_off_noload: assert property (!cfg_loaded_q |-> oclk_en_q == RSC_OCLK_OFF
    && gpio_out_mode_q == RSC_GPIO_ALL_IN)
    else $error("outputs enabled without loaded configuration");

endmodule
`default_nettype wire

// ---- rsc_strap_cfg_tb.sv ----
// rsc_strap_cfg_tb: strap capture, derived settings and start-up order checks.
// assumes rsc_board_model stands for the board and the bench plays the loaders.
`timescale 1ns/1ps
`default_nettype none
module rsc_strap_cfg_tb;
  import rsc_pkg::*;
  logic ref_clk = 1'b0;
  logic reset, mr_assert, pin8_low, ee_seen;
  logic [15:0] drive_en, drive_val, otp_gpio_out, gpio_out_mode_q;
  rsc_pinmap_t pin_map;
  rsc_ovr_t ovr;
  logic otp_programmed, otp_load_done, otp_csum_err, ee_search_done, pll_cal_done, pll_locked;
  logic [3:0] otp_oclk_en, oclk_en_q;
  wire logic master_reset_low;
  wire logic [15:0] gpio_pin;
  rsc_strap_t strap_q;
  logic otp_load_req_q, cfg_loaded_q, ee_search_req_q, regulator_en_q, clocks_en_q;
  logic pll_cal_req_q, pll_lock_en_q, hold_pin_err_q, startup_done_q;
  logic [2:0] sig_bits;
  int err_count = 0;
  int n_compared = 0;
  //////////////////////////////////////////////////////////////////////////////
  rsc_board_model board (.mr_assert, .drive_en, .drive_val, .pin8_low, .master_reset_low, .gpio_pin);
  rsc_strap_cfg dut (.ref_clk, .reset, .master_reset_low, .gpio_pin, .pin_map, .ovr, .otp_programmed,
    .otp_load_done, .otp_csum_err, .otp_oclk_en, .otp_gpio_out, .ee_search_done, .pll_cal_done,
    .pll_locked, .strap_q, .otp_load_req_q, .cfg_loaded_q, .ee_search_req_q, .regulator_en_q,
    .clocks_en_q, .pll_cal_req_q, .pll_lock_en_q, .oclk_en_q, .gpio_out_mode_q, .hold_pin_err_q,
    .startup_done_q);
  // clock and watched flags
  always #2.5 ref_clk = ~ref_clk;
  assign sig_bits = {startup_done_q, ee_search_req_q, otp_load_req_q};
  // remembers any eeprom request since the last boot
  always @(posedge ref_clk)
    if (ee_search_req_q === 1'b1)
      ee_seen = 1'b1;
  //////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // bounded wait, a hang ends the run
  task automatic wait_sig(input int k);
    int n;
    n = 0;
    while (sig_bits[k] !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 200)
    begin
      err_count++;
      $display("BAD wait %0d expected 1 seen 0", k);
      stop_test();
    end
  endtask
  // pins must stay put well past the release, so settle 8 cycles before returning
  task automatic boot(input rsc_pinmap_t m, input logic [15:0] en, input logic [15:0] val);
    @(posedge ref_clk);
    mr_assert <= 1'b1;
    pin_map <= m;
    drive_en <= en;
    drive_val <= val;
    ee_search_done <= 1'b0;
    pll_cal_done <= 1'b0;
    pll_locked <= 1'b0;
    repeat (4) @(posedge ref_clk);
    ee_seen = 1'b0;
    mr_assert <= 1'b0;
    repeat (8) @(posedge ref_clk);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  task automatic s_default;
    boot('0, 16'h0000, 16'h0000);
    check("cfg_index", strap_q.cfg_index, 16'h000f);
    check("aux_i2c", strap_q.aux_i2c, 1);
    check("slave_a2", strap_q.slave_a2, 0);
    check("eeprom_dis", strap_q.eeprom_dis, 0);
  endtask
  task automatic s_sel;
    boot({16'h0164, 32'h0}, 16'h0164, 16'h0124);
    check("cfg_index", strap_q.cfg_index, 16'h000b);
    boot({16'h0a00, 32'h0}, 16'h0800, 16'h0000);
    check("cfg_index", strap_q.cfg_index, 16'h0001);
    boot({16'hf010, 32'h0}, 16'hf010, 16'h8010);
    check("cfg_index", strap_q.cfg_index, 16'h0011);
  endtask
  task automatic s_addr;
    boot({16'h0, 16'h00a0, 16'h0}, 16'h00a0, 16'h0080);
    check("slave_a2", strap_q.slave_a2, 1);
    boot({16'h0, 16'h00a0, 16'h0}, 16'h00a0, 16'h0020);
    check("slave_a2", strap_q.slave_a2, 0);
    boot({16'h0, 16'h00a0, 16'h0}, 16'h02a0, 16'h0080);
    check("aux_i2c", strap_q.aux_i2c, 0);
    check("slave_a2", strap_q.slave_a2, 0);
  endtask
  // unprogrammed part with eeprom disabled runs straight through
  task automatic s_eedis;
    boot({32'h0, 16'h0030}, 16'h0030, 16'h0020);
    check("eeprom_dis", strap_q.eeprom_dis, 1);
    check("pll_cal_req", pll_cal_req_q, 1);
    check("pll_lock_en", pll_lock_en_q, 0);
    pll_cal_done <= 1'b1;
    pll_locked <= 1'b1;
    wait_sig(2);
    check("pll_cal_req", pll_cal_req_q, 0);
    check("pll_lock_en", pll_lock_en_q, 1);
    check("clocks_en", clocks_en_q, 1);
    check("ee_seen", ee_seen, 0);
    check("cfg_loaded", cfg_loaded_q, 0);
    check("oclk_en", oclk_en_q, 16'h0);
    check("gpio_mode", gpio_out_mode_q, 16'h0);
  endtask
  task automatic s_seq(input logic csum);
    otp_programmed <= 1'b1;
    otp_csum_err <= csum;
    boot('0, 16'h0000, 16'h0000);
    wait_sig(0);
    check("regulator_en", regulator_en_q, 0);
    otp_load_done <= 1'b1;
    @(posedge ref_clk);
    otp_load_done <= 1'b0;
    wait_sig(1);
    check("clocks_en", clocks_en_q, 0);
    ee_search_done <= 1'b1;
    pll_cal_done <= 1'b1;
    pll_locked <= 1'b1;
    wait_sig(2);
    check("cfg_loaded", cfg_loaded_q, !csum);
    check("oclk_en", oclk_en_q, csum ? 16'h0 : 16'h5);
    check("gpio_mode", gpio_out_mode_q, csum ? 16'h0 : 16'h00c3);
    otp_programmed <= 1'b0;
  endtask
  task automatic s_hold;
    boot('0, 16'h000f, 16'h0006);
    ovr <= 3'b101;
    @(posedge ref_clk);
    ovr <= 3'b000;
    repeat (3) @(posedge ref_clk);
    check("aux_i2c", strap_q.aux_i2c, 0);
    check("slave_a2", strap_q.slave_a2, 1);
    drive_val <= 16'h0009;
    repeat (6) @(posedge ref_clk);
    check("cfg_index", strap_q.cfg_index, 16'h0006);
  endtask
  task automatic s_pin8;
    pin8_low <= 1'b1;
    boot('0, 16'h0000, 16'h0000);
    check("hold_err", hold_pin_err_q, 1);
    pin8_low <= 1'b0;
    boot('0, 16'h0000, 16'h0000);
    check("hold_err", hold_pin_err_q, 0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    reset = 1'b1;
    mr_assert = 1'b1;
    pin8_low = 1'b0;
    ee_seen = 1'b0;
    drive_en = 16'h0;
    drive_val = 16'h0;
    pin_map = '0;
    ovr = '0;
    otp_programmed = 1'b0;
    otp_load_done = 1'b0;
    otp_csum_err = 1'b0;
    otp_oclk_en = 4'h5;
    otp_gpio_out = 16'h00c3;
    ee_search_done = 1'b0;
    pll_cal_done = 1'b0;
    pll_locked = 1'b0;
    repeat (6) @(posedge ref_clk);
    reset <= 1'b0;
    s_default();
    s_sel();
    s_addr();
    s_eedis();
    s_seq(1'b0);
    s_seq(1'b1);
    s_hold();
    s_pin8();
    stop_test();
  end
endmodule
`default_nettype wire
